// ### rtl/bic_exec.v
// Purpose: Executes branch, port, control, timer, halt and no-op codes.
// Assumes: Fetch delivers one instruction byte per enabled cycle.
// Notes: Timer and interrupt flags are set by outside pulses.
//
// Summary of operation
// - Branch when addressed port bit is zero.
// - Branch on timer flag set, then clear it.
// - Branch on timer flag clear, clear it.
// - Branch on interrupt flag set, clear it.
// - Branch on interrupt flag clear, clear it.
// - Carry branches follow carry flag polarity.
// - Zero branches follow zero flag polarity.
// - Flag branches test one of sixteen flags.
// - Branches replace only low eight PC bits.
// - Port read loads accumulator, updates zero flag.
// - Port write drives accumulator to port.
// - Port bit set/reset touches one bit.
// - Port bit set/reset spoils E register.
// - Control register OR or clear by mask.
// - Timer load from E and accumulator, clears flag.
// - Halt only while port group A low.
// - No-op takes one cycle, only advances the PC.
// - Repeated clear or load-immediate become no-ops.
`timescale 1ns/1ps
`default_nettype none
`include "bic_map.vh"
module bic_exec (
	// Clock, reset, enable
	input wire core_clk,
	input wire rstn,
	input wire clk_en,
	// Instruction byte stream
	input wire [7:0] instr_byte,
	output wire instr_ready,
	// Program counter
	output reg [11:0] pc_reg,
	// Flag events from timer and interrupt hardware
	input wire timer_ovf_pulse,
	input wire ext_irq_pulse,
	// Flags from the ALU side
	input wire carry_flag,
	input wire [15:0] gen_flags,
	// Pointer and ports
	input wire [3:0] ptr_low_nib,
	input wire [3:0] port_in_val,
	input wire [3:0] port_group_a,
	output reg [3:0] port_out_val,
	output reg port_out_we,
	// Architectural state shown out
	output reg [3:0] work_nib_reg,
	output reg [3:0] e_reg,
	output reg zero_flag,
	output reg timer_overflow_flag,
	output reg ext_irq_flag,
	output reg [3:0] ctrl_reg,
	output reg [7:0] timer_reg,
	output reg halted
);
	// --------------------------------------------------------------
	// Reset release and state
	// --------------------------------------------------------------
	localparam ST_FETCH = 1'b0;
	localparam ST_SECOND = 1'b1;
	reg [1:0] rst_sync_reg;
	wire rst_n_int;
	reg state_reg;
	reg [7:0] op_reg;
	reg last_cla_reg;
	reg last_li_reg;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	// The release is synchronised so no register leaves reset a cycle early.
	assign rst_n_int = rst_sync_reg[1];
	assign instr_ready = !halted;

	// --------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------
	// Branch on a port bit; the low two bits pick the bit.
	function is_br_port_clr;
		input [7:0] op;
		begin
			is_br_port_clr = (op & `BIC_MASK_HI6) == `BIC_OP_BR_PORT_CLR;
		end
	endfunction

	function is_br_port_set;
		input [7:0] op;
		begin
			is_br_port_set = (op & `BIC_MASK_HI6) == `BIC_OP_BR_PORT_SET;
		end
	endfunction

	// Branch on a general flag; the low nibble picks the flag.
	function is_br_flag_set;
		input [7:0] op;
		begin
			is_br_flag_set = (op & `BIC_MASK_HI4) == `BIC_OP_BR_FLAG_SET;
		end
	endfunction

	function is_br_flag_clr;
		input [7:0] op;
		begin
			is_br_flag_clr = (op & `BIC_MASK_HI4) == `BIC_OP_BR_FLAG_CLR;
		end
	endfunction

	// Branches that test and then clear the timer flag.
	function is_timer_br;
		input [7:0] op;
		begin
			is_timer_br = op == `BIC_OP_BR_TIMER_SET ||
				op == `BIC_OP_BR_TIMER_CLR;
		end
	endfunction

	// Branches that test and then clear the interrupt flag.
	function is_irq_br;
		input [7:0] op;
		begin
			is_irq_br = op == `BIC_OP_BR_IRQ_SET || op == `BIC_OP_BR_NO_IRQ;
		end
	endfunction

	// Branches on a single fixed flag.
	function is_fixed_br;
		input [7:0] op;
		begin
			is_fixed_br = is_timer_br(op) || is_irq_br(op) ||
				op == `BIC_OP_BR_ZERO || op == `BIC_OP_BR_NONZERO ||
				op == `BIC_OP_BR_CARRY_SET || op == `BIC_OP_BR_NO_CARRY;
		end
	endfunction

	// Port bit set and reset.
	function is_port_bit_set;
		input [7:0] op;
		begin
			is_port_bit_set = (op & `BIC_MASK_HI6) == `BIC_OP_PORT_BIT_SET;
		end
	endfunction

	function is_port_bit_op;
		input [7:0] op;
		begin
			is_port_bit_op = is_port_bit_set(op) ||
				(op & `BIC_MASK_HI6) == `BIC_OP_PORT_BIT_CLR;
		end
	endfunction

	// Clear shares the load-immediate pattern with a zero field.
	function is_clear_acc;
		input [7:0] op;
		begin
			is_clear_acc = op == `BIC_OP_CLEAR_ACC;
		end
	endfunction

	function is_load_imm;
		input [7:0] op;
		begin
			is_load_imm = op[7:4] == `BIC_OP_LOAD_IMM_HI && !is_clear_acc(op);
		end
	endfunction

	// Codes that take their second byte in the next machine cycle.
	function is_two_byte;
		input [7:0] op;
		begin
			is_two_byte = is_br_port_clr(op) || is_br_port_set(op) ||
				is_br_flag_set(op) || is_br_flag_clr(op) ||
				is_fixed_br(op) || op == `BIC_OP_CTRL;
		end
	endfunction

	wire port_bit;
	wire [3:0] port_upd;
	bic_port_bit u_bit (
		.port_val(port_in_val),
		.bit_idx(state_reg == ST_SECOND ? op_reg[1:0] : instr_byte[1:0]),
		.set_not_clr(is_port_bit_set(instr_byte)),
		.bit_val(port_bit),
		.port_upd(port_upd)
	);

	// --------------------------------------------------------------
	// Branch condition
	// --------------------------------------------------------------
	// Branch condition of the held first byte.
	reg cond;
	always @* begin
		cond = 1'b0;
		if (is_br_port_clr(op_reg))
			cond = !port_bit;
		else if (is_br_port_set(op_reg))
			cond = port_bit;
		else if (is_br_flag_set(op_reg))
			cond = gen_flags[op_reg[3:0]];
		else if (is_br_flag_clr(op_reg))
			cond = !gen_flags[op_reg[3:0]];
		else begin
			case (op_reg)
				`BIC_OP_BR_TIMER_SET: cond = timer_overflow_flag;
				`BIC_OP_BR_TIMER_CLR: cond = !timer_overflow_flag;
				`BIC_OP_BR_IRQ_SET: cond = ext_irq_flag;
				`BIC_OP_BR_NO_IRQ: cond = !ext_irq_flag;
				`BIC_OP_BR_CARRY_SET: cond = carry_flag;
				`BIC_OP_BR_NO_CARRY: cond = !carry_flag;
				`BIC_OP_BR_ZERO: cond = zero_flag;
				`BIC_OP_BR_NONZERO: cond = !zero_flag;
				default: cond = 1'b0;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Execution
	// --------------------------------------------------------------
	// Set pulses win over the clear by an instruction in the same cycle.
	wire clr_tmf = state_reg == ST_SECOND && is_timer_br(op_reg);
	wire clr_irq = state_reg == ST_SECOND && is_irq_br(op_reg);
	wire fetch_now = state_reg == ST_FETCH && !halted;
	wire load_tm = fetch_now && instr_byte == `BIC_OP_TIMER_LOAD;

	// --------------------------------------------------------------
	// Flag events
	// --------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			timer_overflow_flag <= 1'b0;
			ext_irq_flag <= 1'b0;
		end else if (clk_en) begin
			if (timer_ovf_pulse)
				timer_overflow_flag <= 1'b1;
			else if (clr_tmf || load_tm)
				timer_overflow_flag <= 1'b0;
			if (ext_irq_pulse)
				ext_irq_flag <= 1'b1;
			else if (clr_irq)
				ext_irq_flag <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Program counter and architectural state
	// --------------------------------------------------------------
	// Every register here holds while clk_en is low, so a stall loses nothing.
	always @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			state_reg <= ST_FETCH;
			op_reg <= 8'h00;
			pc_reg <= `BIC_PC_RST;
			port_out_val <= 4'h0;
			port_out_we <= 1'b0;
			work_nib_reg <= 4'h0;
			e_reg <= 4'h0;
			zero_flag <= 1'b0;
			ctrl_reg <= `BIC_CTRL_RST;
			timer_reg <= `BIC_TIMER_RST;
			halted <= 1'b0;
			last_cla_reg <= 1'b0;
			last_li_reg <= 1'b0;
		end else if (clk_en) begin
			port_out_we <= 1'b0;
			case (state_reg)
				ST_FETCH: begin
					if (!halted) begin
						op_reg <= instr_byte;
						pc_reg <= pc_reg + 12'h001;
						last_cla_reg <= is_clear_acc(instr_byte);
						last_li_reg <= is_load_imm(instr_byte);
						if (is_two_byte(instr_byte)) begin
							state_reg <= ST_SECOND;
						end else if (is_clear_acc(instr_byte)) begin
							if (!last_cla_reg)
								work_nib_reg <= 4'h0;
						end else if (is_load_imm(instr_byte)) begin
							if (!last_li_reg)
								work_nib_reg <= instr_byte[3:0];
						end else if (instr_byte == `BIC_OP_PORT_READ) begin
							work_nib_reg <= port_in_val;
							zero_flag <= port_in_val == 4'h0;
						end else if (instr_byte == `BIC_OP_PORT_WRITE) begin
							port_out_val <= work_nib_reg;
							port_out_we <= 1'b1;
						end else if (is_port_bit_op(instr_byte)) begin
							port_out_val <= port_upd;
							port_out_we <= 1'b1;
							// The E register is scratch for this sequence.
							e_reg <= `BIC_E_JUNK;
						end else if (load_tm) begin
							timer_reg <= {e_reg, work_nib_reg};
						end else if (instr_byte == `BIC_OP_HALT) begin
							// Halting with port A active would never wake up.
							if (port_group_a == 4'h0)
								halted <= 1'b1;
						end
						// A no-op falls through with only the PC moving.
					end
				end
				ST_SECOND: begin
					state_reg <= ST_FETCH;
					if (op_reg == `BIC_OP_CTRL) begin
						if (instr_byte[7:4] == `BIC_CTRL_SET_PFX)
							ctrl_reg <= ctrl_reg | instr_byte[3:0];
						else if (instr_byte[7:4] == `BIC_CTRL_CLR_PFX)
							ctrl_reg <= ctrl_reg & ~instr_byte[3:0];
						pc_reg <= pc_reg + 12'h001;
					end else if (cond) begin
						// The PC already points past the first byte here.
						pc_reg <= {pc_reg[11:8], instr_byte};
					end else begin
						pc_reg <= pc_reg + 12'h001;
					end
				end
				default: state_reg <= ST_FETCH;
			endcase
		end
	end
endmodule // bic_exec
`default_nettype wire

// ### pkg/bic_map.vh
// Purpose: Constants for the branch and I/O instruction executor.
// Assumes: One machine cycle per enabled clock edge.
// Notes: Opcodes are first-byte codes; masks compare the upper bits.
`ifndef BIC_MAP_VH
`define BIC_MAP_VH

`define BIC_OP_BR_PORT_CLR 8'h38
`define BIC_OP_BR_PORT_SET 8'h78
`define BIC_OP_BR_TIMER_SET 8'h7C
`define BIC_OP_BR_TIMER_CLR 8'h3C
`define BIC_OP_BR_IRQ_SET 8'h7D
`define BIC_OP_BR_NO_IRQ 8'h3D
`define BIC_OP_BR_ZERO 8'h7E
`define BIC_OP_BR_NONZERO 8'h3E
`define BIC_OP_BR_CARRY_SET 8'h7F
`define BIC_OP_BR_NO_CARRY 8'h3F
`define BIC_OP_BR_FLAG_SET 8'hD0
`define BIC_OP_BR_FLAG_CLR 8'h90
`define BIC_OP_PORT_READ 8'h0C
`define BIC_OP_PORT_WRITE 8'h61
`define BIC_OP_PORT_BIT_SET 8'h04
`define BIC_OP_PORT_BIT_CLR 8'h24
`define BIC_OP_CTRL 8'h2C
`define BIC_OP_TIMER_LOAD 8'hF6
`define BIC_OP_HALT 8'hFF
`define BIC_OP_NOP 8'h00
`define BIC_OP_CLEAR_ACC 8'hC0
`define BIC_OP_LOAD_IMM_HI 4'hC
`define BIC_CTRL_SET_PFX 4'h8
`define BIC_CTRL_CLR_PFX 4'h9
`define BIC_MASK_HI4 8'hF0
`define BIC_MASK_HI6 8'hFC
`define BIC_CTRL_RST 4'h0
`define BIC_FLAGS_RST 16'h0000
`define BIC_PC_RST 12'h000
`define BIC_TIMER_RST 8'h00
`define BIC_E_JUNK 4'hF

`endif

// ### rtl/bic_port_bit.v
// Purpose: Port bit select, test and single-bit update.
// Assumes: Bit index is the two-bit immediate field.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module bic_port_bit (
	// Port value and bit index
	input wire [3:0] port_val,
	input wire [1:0] bit_idx,
	input wire set_not_clr,
	// Results
	output wire bit_val,
	output wire [3:0] port_upd
);
	genvar i;
	assign bit_val = port_val[bit_idx];
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_bit
			assign port_upd[i] = (bit_idx == i) ? set_not_clr : port_val[i];
		end
	endgenerate
endmodule // bic_port_bit
`default_nettype wire

// ### verification/bic_exec_sva.sv
// Purpose: Port-level checks for the branch and I/O executor.
// Assumes: Bound to bic_exec; one clock domain.
// Notes: Second-byte state is not visible, so checks avoid it.
`timescale 1ns/1ps
`default_nettype none
`include "bic_map.vh"
module bic_exec_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Watched ports
	input wire logic clk_en,
	input wire logic [7:0] instr_byte,
	input wire logic instr_ready,
	input wire logic [11:0] pc_reg,
	input wire logic timer_ovf_pulse,
	input wire logic ext_irq_pulse,
	input wire logic [3:0] port_group_a,
	input wire logic port_out_we,
	input wire logic [3:0] e_reg,
	input wire logic timer_overflow_flag,
	input wire logic ext_irq_flag,
	input wire logic halted
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_ready; instr_ready == !halted; endproperty
	a_ready: assert property (p_ready) else $error("ready wrong");
	property p_hold; halted |=> halted; endproperty
	a_hold: assert property (p_hold) else $error("halt left");
	property p_stall; halted |=> $stable(pc_reg); endproperty
	a_stall: assert property (p_stall) else $error("pc moved");
	property p_halt_pa;
		$rose(halted) |-> $past(port_group_a) == 4'h0 &&
			$past(instr_byte) == `BIC_OP_HALT;
	endproperty
	a_halt_pa: assert property (p_halt_pa) else $error("bad halt");
	property p_tmr;
		timer_ovf_pulse && clk_en && !halted |=> timer_overflow_flag;
	endproperty
	a_tmr: assert property (p_tmr) else $error("tmr flag");
	property p_irq; ext_irq_pulse && clk_en && !halted |=> ext_irq_flag;
	endproperty
	a_irq: assert property (p_irq) else $error("irq flag");
	property p_we;
		$rose(port_out_we) |-> $past(instr_byte) == `BIC_OP_PORT_WRITE ||
			($past(instr_byte) & 8'hDC) == 8'h04;
	endproperty
	a_we: assert property (p_we) else $error("stray write");
	property p_e; e_reg != $past(e_reg) |-> e_reg == `BIC_E_JUNK;
	endproperty
	a_e: assert property (p_e) else $error("e changed");
	property p_freeze; !clk_en |=> $stable(pc_reg); endproperty
	a_freeze: assert property (p_freeze) else $error("pc moved");
	c_halt: cover property ($rose(halted));
	c_we: cover property (port_out_we);
	c_tmr: cover property (timer_overflow_flag ##1 !timer_overflow_flag);
endmodule // bic_exec_sva
bind bic_exec bic_exec_sva u_sva (.core_clk, .rstn, .clk_en, .instr_byte,
	.instr_ready, .pc_reg, .timer_ovf_pulse, .ext_irq_pulse, .port_group_a,
	.port_out_we, .e_reg, .timer_overflow_flag, .ext_irq_flag, .halted);
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the branch and I/O executor.
// Assumes: Each test starts from reset, so the model PC starts at zero.
// Notes: PC is not modelled after timer load; its length is left open.
`timescale 1ns/1ps
`default_nettype none
`include "bic_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
	logic core_clk = 0, rstn = 0, tp = 0, ip = 0, cf = 0, en = 1;
	logic [7:0] ib = 0;
	logic [15:0] gf = 0;
	logic [3:0] pin = 0, pa = 0, pa_n = 0;
	wire [11:0] pc_reg;
	wire [3:0] port_out_val, work_nib_reg, e_reg, ctrl_reg;
	wire [7:0] timer_reg;
	wire instr_ready, port_out_we, zero_flag, timer_overflow_flag;
	wire ext_irq_flag, halted;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	int pc, tf, xf, v, t, tg, c, k;
	logic [7:0] b;
	logic [7:0] ops [12] = '{8'h38, 8'h78, 8'h7C, 8'h3C, 8'h7D, 8'h3D,
		8'h7E, 8'h3E, 8'h7F, 8'h3F, 8'hD0, 8'h90};
	always #2 core_clk = ~core_clk;
	bic_exec u_dut (.core_clk, .rstn, .clk_en(en), .instr_byte(ib),
		.instr_ready, .pc_reg, .timer_ovf_pulse(tp), .ext_irq_pulse(ip),
		.carry_flag(cf), .gen_flags(gf), .ptr_low_nib(4'h0),
		.port_in_val(pin), .port_group_a(pa), .port_out_val, .port_out_we,
		.work_nib_reg, .e_reg, .zero_flag, .timer_overflow_flag,
		.ext_irq_flag, .ctrl_reg, .timer_reg, .halted);
	task test_done;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// A hang counts as a mismatch; the tests need well under this.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end
	task rst;
		@(negedge core_clk) rstn = 0;
		ib = 0;
		repeat (3) @(negedge core_clk);
		rstn = 1;
		@(posedge core_clk);
		@(negedge core_clk);
		pc = 0;
	endtask
	task op(input logic [7:0] bt, input logic pt, input logic pi);
		@(negedge core_clk) ib = bt;
		tp = pt;
		ip = pi;
		pa = pa_n;
		pc++;
		@(posedge core_clk);
		#1;
	endtask
	initial begin
		v = $urandom(32'h1816);
		repeat (60) begin
			rst;
			tf = $urandom % 2;
			xf = $urandom % 2;
			v = $urandom % 16;
			cf = $urandom % 2;
			gf = $urandom;
			pin = v;
			op(`BIC_OP_NOP, tf, xf);
			`CHK(pc_reg, pc)
			op(`BIC_OP_PORT_READ, 0, 0);
			`CHK(work_nib_reg, v)
			`CHK(zero_flag, v == 0)
			k = $urandom % 12;
			t = $urandom % 16;
			tg = $urandom % 256;
			b = ops[k] | (k < 2 ? t % 4 : k > 9 ? t : 0);
			case (k)
				0: c = !pin[t % 4];
				1: c = pin[t % 4];
				2: c = tf;
				3: c = !tf;
				4: c = xf;
				5: c = !xf;
				6: c = v == 0;
				7: c = v != 0;
				8: c = cf;
				9: c = !cf;
				10: c = gf[t];
				default: c = !gf[t];
			endcase
			op(b, 0, 0);
			`CHK(pc_reg, pc)
			op(tg, 0, 0);
			if (c) pc = tg;
			`CHK(pc_reg, pc)
			`CHK(timer_overflow_flag, k == 2 || k == 3 ? 0 : tf)
			`CHK(ext_irq_flag, k == 4 || k == 5 ? 0 : xf)
		end
		$display("branch test done");
		repeat (4) begin
			rst;
			pa_n = $urandom % 15 + 1;
			v = $urandom % 15 + 1;
			t = $urandom % 4;
			k = $urandom % 16;
			c = $urandom % 16;
			pin = $urandom;
			op(8'hC0 | v, 0, 0);
			op(8'hC0 | ($urandom % 15 + 1), 0, 0);
			`CHK(work_nib_reg, v)
			op(`BIC_OP_PORT_WRITE, 0, 0);
			`CHK(port_out_we, 1)
			`CHK(port_out_val, v)
			op(`BIC_OP_PORT_BIT_SET | t, 0, 0);
			`CHK(port_out_val, pin | (1 << t))
			`CHK(e_reg, `BIC_E_JUNK)
			op(`BIC_OP_PORT_BIT_CLR | t, 0, 0);
			`CHK(port_out_val, pin & ~(1 << t))
			op(`BIC_OP_CTRL, 0, 0);
			op(8'h80 | k, 0, 0);
			op(`BIC_OP_CTRL, 0, 0);
			op(8'h90 | c, 0, 0);
			`CHK(ctrl_reg, k & ~c)
			@(negedge core_clk) en = 0;
			op(`BIC_OP_NOP, 1, 0);
			`CHK(pc_reg, pc - 1)
			`CHK(timer_overflow_flag, 0)
			@(negedge core_clk) en = 1;
			tp = 0;
			op(`BIC_OP_NOP, 1, 0);
			`CHK(pc_reg, pc)
			op(`BIC_OP_HALT, 0, 0);
			`CHK(halted, 0)
			op(`BIC_OP_TIMER_LOAD, 0, 0);
			op(`BIC_OP_NOP, 0, 0);
			`CHK(timer_reg, {`BIC_E_JUNK, v[3:0]})
			`CHK(timer_overflow_flag, 0)
			pa_n = 0;
			op(`BIC_OP_HALT, 0, 0);
			op(`BIC_OP_NOP, 0, 0);
			`CHK(halted, 1)
			`CHK(instr_ready, 0)
		end
		$display("port and control test done");
		test_done();
	end
endmodule // tb_top
`default_nettype wire
